// >>> src/dcc_consts.vh
// Purpose: Constants for the DMA channel configuration register block
// Assumes: Avalon-MM word addressing by byte address, 32-bit data
// Notes:   Offsets are byte addresses; channel n adds n * stride
`ifndef DCC_CONSTS_VH
`define DCC_CONSTS_VH
`define DCC_NUM_CH          8
`define DCC_CH_STRIDE       12'h020
`define DCC_OFS_CTRL        12'h100
`define DCC_OFS_CFG         12'h104
`define DCC_OFS_SRC         12'h108
`define DCC_OFS_DST         12'h10c
`define DCC_OFS_LLP         12'h110
`define DCC_OFS_BASE_LO     12'h100
`define DCC_OFS_BASE_HI     12'h1ff
`define DCC_CTRL_EN_BIT     0
`define DCC_CTRL_HS_BIT     1
`define DCC_CFG_CNT_LSB     16
`define DCC_CFG_CNT_MSB     19
`define DCC_CFG_DHE_BIT     13
`define DCC_CFG_DRS_LSB     9
`define DCC_CFG_DRS_MSB     12
`define DCC_CFG_BUSY_BIT    8
`define DCC_CFG_SHE_BIT     7
`define DCC_CFG_SRS_LSB     3
`define DCC_CFG_SRS_MSB     6
`define DCC_CFG_ABT_BIT     2
`define DCC_CFG_ERR_BIT     1
`define DCC_CFG_TC_BIT      0
`define DCC_CFG_RST_MASKS   3'h7
`define DCC_CFG_RST_HE      1'h1
`define DCC_CFG_RST_RS      4'h0
`define DCC_ADDR_RST        32'h00000000
`define DCC_LLP_MASTER_BIT  0
`define DCC_UNMAPPED_DATA   32'h00000000
`endif

// >>> src/dcc_chan_ram.v
// Purpose: Per-channel address words, four rows per channel
// Assumes: One write port and one read port, registered read data
// Notes:   Holds source, destination and descriptor pointer words
module dcc_chan_ram (
   input  wire        clk_sys_in,  // System clock
   input  wire        wr_en_in,    // Write strobe
   input  wire [4:0]  wr_addr_in,  // Channel * 4 + word
   input  wire [31:0] wr_data_in,  // Write data
   input  wire [4:0]  rd_addr_in,  // Read row
   output reg  [31:0] rd_data_out  // Registered read data
);
   reg [31:0] mem_q [0:31];
   integer    i;

   // Cleared contents at start
   initial begin
      for (i = 0; i < 32; i = i + 1) begin
         mem_q[i] = 32'h00000000;
      end
   end

   // Write and registered read
   always @(posedge clk_sys_in) begin
      if (wr_en_in) begin
         mem_q[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem_q[rd_addr_in];
   end
endmodule // dcc_chan_ram

// >>> src/dcc_regs.v
// Purpose: Eight-channel DMA configuration and addressing registers
// Assumes: Avalon-MM slave with waitrequest, single clock, async reset
// Notes:   Transfer engine sits outside; it reports events on ports
`include "dcc_consts.vh"
module dcc_regs (
   input  wire        clk_sys_in,         // System clock
   input  wire        rst_n_in,           // Async reset, active low
   input  wire [11:0] avs_address_in,     // Byte address
   input  wire        avs_read_in,        // Read request
   input  wire        avs_write_in,       // Write request
   input  wire [31:0] avs_writedata_in,   // Write data
   input  wire [3:0]  avs_byteenable_in,  // Byte enables
   output reg  [31:0] avs_readdata_out,   // Read data
   output reg         avs_waitrequest_out,// Wait request
   input  wire [15:0] dma_req_in,         // Peripheral request lines
   input  wire [7:0]  active_in,          // Engine: channel active
   input  wire [7:0]  block_done_in,      // Engine: block finished pulse
   input  wire [7:0]  chain_on_in,        // Engine: chained mode level
   input  wire [7:0]  error_in,           // Engine: error pulse
   input  wire [7:0]  abort_in,           // Engine: abort pulse
   input  wire [7:0]  tc_in,              // Engine: terminal count pulse
   input  wire [7:0]  end_wr_in,          // Engine: write ending addresses
   input  wire [31:0] src_end_in,         // Ending source address
   input  wire [31:0] dst_end_in,         // Ending destination address
   input  wire [2:0]  end_ch_in,          // Channel of ending addresses
   output reg  [7:0]  channel_on_out,     // Channel enables
   output reg  [7:0]  src_go_out,         // Source side may proceed
   output reg  [7:0]  dst_go_out,         // Destination side may proceed
   output reg  [7:0]  busy_out,           // One-hot busy
   output reg  [7:0]  irq_abort_out,      // Unmasked abort events
   output reg  [7:0]  irq_error_out,      // Unmasked error events
   output reg  [7:0]  irq_tc_out          // Unmasked terminal count events
);
   // Per-channel control and configuration bits
   reg  [7:0]  hs_mode_q;
   reg  [7:0]  dhe_q;
   reg  [7:0]  she_q;
   reg  [31:0] drs_q;
   reg  [31:0] srs_q;
   reg  [7:0]  abt_msk_q;
   reg  [7:0]  err_msk_q;
   reg  [7:0]  tc_msk_q;
   reg  [31:0] cnt_q;
   reg  [7:0]  busy_q;
   reg  [15:0] req_s1_q;
   reg  [15:0] req_s2_q;
   reg  [7:0]  act_s1_q;
   reg  [7:0]  act_s2_q;
   // Bus handshake state
   reg         phase_q;
   reg         rd_ram_q;
   reg  [2:0]  rd_ch_q;
   reg  [2:0]  rd_reg_q;
   reg         rd_hit_q;
   wire [31:0] ram_rd;
   // Decoded request
   wire        req      = (avs_read_in | avs_write_in) & ~phase_q;
   wire [11:0] rel      = avs_address_in - `DCC_OFS_BASE_LO;
   wire [2:0]  dec_ch   = rel[7:5];
   wire [2:0]  dec_reg  = rel[4:2];
   wire        in_rng   = (avs_address_in >= `DCC_OFS_BASE_LO) &&
                          (avs_address_in <= `DCC_OFS_BASE_HI);
   wire        hit      = in_rng && (dec_reg <= 3'h4) && (avs_address_in[1:0] == 2'h0);
   wire        wr_full  = (avs_byteenable_in == 4'hf);
   wire        sw_wr    = req & avs_write_in & hit;
   wire        is_ram   = (dec_reg >= 3'h2) && (dec_reg <= 3'h4);
   // Word within a channel row, cut to the two row bits on purpose
   wire [2:0]  ram_word = dec_reg - 3'h2;
   wire [4:0]  ram_row  = {dec_ch, ram_word[1:0]};
   // Memory write mux: engine ending addresses beat software
   reg         ram_we;
   reg  [4:0]  ram_wa;
   reg  [31:0] ram_wd;
   reg         end_pend_q;
   reg  [2:0]  end_ch_q;
   reg  [31:0] end_dst_val_q;
   wire        end_any  = |end_wr_in;

   // Memory write port selection
   always @* begin
      ram_we = 1'b0;
      ram_wa = 5'h00;
      ram_wd = 32'h00000000;
      if (end_any) begin
         ram_we = 1'b1;
         ram_wa = {end_ch_in, 2'h0};
         ram_wd = src_end_in;
      end else if (end_pend_q) begin
         ram_we = 1'b1;
         ram_wa = {end_ch_q, 2'h1};
         ram_wd = end_dst_val_q;
      end else if (sw_wr && is_ram && wr_full) begin
         ram_we = 1'b1;
         ram_wa = ram_row;
         ram_wd = avs_writedata_in;
      end
   end

   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         end_pend_q    <= 1'b0;
         end_ch_q      <= 3'h0;
         end_dst_val_q <= `DCC_ADDR_RST;
      end else begin
         end_pend_q <= end_any;
         if (end_any) begin
            end_ch_q      <= end_ch_in;
            end_dst_val_q <= dst_end_in;
         end
      end
   end

   // pointer bit zero kept as master select
   dcc_chan_ram u_ram (
      .clk_sys_in  (clk_sys_in),
      .wr_en_in    (ram_we),
      .wr_addr_in  (ram_wa),
      .wr_data_in  (ram_wd),
      .rd_addr_in  (ram_row),
      .rd_data_out (ram_rd)
   );

   // Input synchronisers for request lines and engine level
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         req_s1_q <= 16'h0000;
         req_s2_q <= 16'h0000;
         act_s1_q <= 8'h00;
         act_s2_q <= 8'h00;
      end else begin
         req_s1_q <= dma_req_in;
         req_s2_q <= req_s1_q;
         act_s1_q <= active_in;
         act_s2_q <= act_s1_q;
      end
   end

   // Avalon handshake: one wait cycle, answer on the second
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase_q             <= 1'b0;
         rd_ram_q            <= 1'b0;
         rd_ch_q             <= 3'h0;
         rd_reg_q            <= 3'h0;
         rd_hit_q            <= 1'b0;
         avs_waitrequest_out <= 1'b1;
      end else begin
         phase_q             <= req;
         avs_waitrequest_out <= ~req;
         if (req) begin
            rd_ram_q <= is_ram;
            rd_ch_q  <= dec_ch;
            rd_reg_q <= dec_reg;
            rd_hit_q <= hit;
         end
      end
   end

   // Read data from registers or memory
   always @* begin
      avs_readdata_out = `DCC_UNMAPPED_DATA;
      if (rd_hit_q) begin
         if (rd_ram_q) begin
            avs_readdata_out = ram_rd;
         end else if (rd_reg_q == 3'h0) begin
            avs_readdata_out = {30'h0, hs_mode_q[rd_ch_q], channel_on_out[rd_ch_q]};
         end else begin
            avs_readdata_out = {12'h000, cnt_q[rd_ch_q*4 +: 4], 2'h0,
               dhe_q[rd_ch_q], drs_q[rd_ch_q*4 +: 4], busy_q[rd_ch_q],
               she_q[rd_ch_q], srs_q[rd_ch_q*4 +: 4], abt_msk_q[rd_ch_q],
               err_msk_q[rd_ch_q], tc_msk_q[rd_ch_q]};
         end
      end
   end

   // Per-channel control, configuration and counters
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_ch
         wire ctl_wr = sw_wr && (dec_ch == g) && (dec_reg == 3'h0);
         wire cfg_wr = sw_wr && (dec_ch == g) && (dec_reg == 3'h1);
         wire en_new = ctl_wr & avs_writedata_in[`DCC_CTRL_EN_BIT];
         always @(posedge clk_sys_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               channel_on_out[g]  <= 1'b0;
               hs_mode_q[g]       <= 1'b0;
               dhe_q[g]           <= `DCC_CFG_RST_HE;
               she_q[g]           <= `DCC_CFG_RST_HE;
               drs_q[g*4 +: 4]    <= `DCC_CFG_RST_RS;
               srs_q[g*4 +: 4]    <= `DCC_CFG_RST_RS;
               abt_msk_q[g]       <= 1'b1;
               err_msk_q[g]       <= 1'b1;
               tc_msk_q[g]        <= 1'b1;
               cnt_q[g*4 +: 4]    <= 4'h0;
               src_go_out[g]      <= 1'b0;
               dst_go_out[g]      <= 1'b0;
               irq_abort_out[g]   <= 1'b0;
               irq_error_out[g]   <= 1'b0;
               irq_tc_out[g]      <= 1'b0;
            end else begin
               if (ctl_wr) begin
                  channel_on_out[g] <= avs_writedata_in[`DCC_CTRL_EN_BIT];
                  hs_mode_q[g]      <= avs_writedata_in[`DCC_CTRL_HS_BIT];
               end
               if (cfg_wr) begin
                  dhe_q[g]        <= avs_writedata_in[`DCC_CFG_DHE_BIT];
                  drs_q[g*4 +: 4] <= avs_writedata_in[`DCC_CFG_DRS_MSB:`DCC_CFG_DRS_LSB];
                  she_q[g]        <= avs_writedata_in[`DCC_CFG_SHE_BIT];
                  srs_q[g*4 +: 4] <= avs_writedata_in[`DCC_CFG_SRS_MSB:`DCC_CFG_SRS_LSB];
                  abt_msk_q[g]    <= avs_writedata_in[`DCC_CFG_ABT_BIT];
                  err_msk_q[g]    <= avs_writedata_in[`DCC_CFG_ERR_BIT];
                  tc_msk_q[g]     <= avs_writedata_in[`DCC_CFG_TC_BIT];
               end
               if (en_new && !channel_on_out[g]) begin
                  cnt_q[g*4 +: 4] <= 4'h0;
               end else if ((block_done_in[g] & chain_on_in[g]) | error_in[g] | abort_in[g]) begin
                  cnt_q[g*4 +: 4] <= cnt_q[g*4 +: 4] + 4'h1;
               end
               src_go_out[g] <= channel_on_out[g] & (~hs_mode_q[g] | ~she_q[g] |
                                req_s2_q[srs_q[g*4 +: 4]]);
               dst_go_out[g] <= channel_on_out[g] & (~hs_mode_q[g] | ~dhe_q[g] |
                                req_s2_q[drs_q[g*4 +: 4]]);
               irq_abort_out[g] <= abort_in[g] & ~abt_msk_q[g];
               irq_error_out[g] <= error_in[g] & ~err_msk_q[g];
               irq_tc_out[g]    <= tc_in[g] & ~tc_msk_q[g];
            end
         end
      end
   endgenerate

   // one-hot busy, lowest active channel wins
   always @(posedge clk_sys_in or negedge rst_n_in) begin : p_busy
      integer k;
      reg     found;
      if (!rst_n_in) begin
         busy_q   <= 8'h00;
         busy_out <= 8'h00;
      end else begin
         found = 1'b0;
         for (k = 0; k < 8; k = k + 1) begin
            busy_q[k] <= act_s2_q[k] & ~found;
            found     = found | act_s2_q[k];
         end
         busy_out <= busy_q;
      end
   end
endmodule // dcc_regs

// >>> sim/dcc_regs_sva.sv
// Purpose: Port checker for the channel register block
// Assumes: One clock, async active-low reset
// Notes:   Bound to the design from the bench top file
module dcc_regs_sva (
   input wire logic        clk_sys_in,          // Clock
   input wire logic        rst_n_in,            // Reset, active low
   input wire logic        avs_read_in,         // Read request
   input wire logic        avs_write_in,        // Write request
   input wire logic        avs_waitrequest_out, // Wait request
   input wire logic [7:0]  active_in,           // Engine activity
   input wire logic [7:0]  busy_out,            // Busy flags
   input wire logic [7:0]  abort_in,            // Abort events
   input wire logic [7:0]  error_in,            // Error events
   input wire logic [7:0]  tc_in,               // Terminal count events
   input wire logic [7:0]  irq_abort_out,       // Abort interrupts
   input wire logic [7:0]  irq_error_out,       // Error interrupts
   input wire logic [7:0]  irq_tc_out           // Terminal count interrupts
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   // Request taken, then one answer cycle
   sequence s_taken;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence s_answer;
      !avs_waitrequest_out ##1 avs_waitrequest_out;
   endsequence

   chk_bus_answer: assert property (s_taken |=> s_answer)
      else $error("bus access not answered in one cycle");
   chk_idle_quiet: assert property (
      !avs_read_in && !avs_write_in && avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("answer without request");
   chk_busy_single: assert property ($onehot0(busy_out))
      else $error("more than one channel busy");
   chk_busy_lowest: assert property (busy_out != 8'h00 |->
      busy_out == ($past(active_in, 4) & (~$past(active_in, 4) + 8'h01)))
      else $error("busy flag not the lowest active channel");
   chk_busy_idle: assert property ((active_in == 8'h00) [*5] |-> busy_out == 8'h00)
      else $error("busy without activity");
   chk_abort_cause: assert property (
      (irq_abort_out & ~$past(abort_in)) == 8'h00)
      else $error("abort interrupt without event");
   chk_error_cause: assert property (
      (irq_error_out & ~$past(error_in)) == 8'h00)
      else $error("error interrupt without event");
   chk_tc_cause: assert property (
      (irq_tc_out & ~$past(tc_in)) == 8'h00)
      else $error("terminal count interrupt without event");
endmodule // dcc_regs_sva

// >>> sim/dcc_periph_model.sv
// Purpose: Peripherals that pace the channels with request lines
// Assumes: Bench says which peripherals can move data
// Notes:   Requests change just after a clock edge
module dcc_periph_model (
   input  wire logic        clk_sys_in,  // Clock
   input  wire logic        rst_n_in,    // Reset, active low
   input  wire logic [15:0] ready_in,    // Peripherals able to proceed
   output logic      [15:0] dma_req_out  // Request lines
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dma_req_out <= 16'h0000;
      end else begin
         dma_req_out <= ready_in;
      end
   end
endmodule // dcc_periph_model

// >>> sim/tb_dma_channel_config_regs.sv
// Purpose: Self-checking bench for the channel register block
// Assumes: One wait state per access, engine events as pulses
// Notes:   Request lines come from the peripheral model
module tb_dma_channel_config_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys_in, rst_n_in, rd, wr, wreq;
   logic [11:0] adr, b;
   logic [31:0] wd, rdat, q, se, de;
   logic [7:0]  act, bd, chn, er, ab, tc, ew, chon, sgo, dgo, busy, ia, ie, it;
   logic [2:0]  ec;
   logic [15:0] rdy, req;
   logic [23:0] irq_q;
   int          err_total, n_tests;

   dcc_regs i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
      .avs_byteenable_in(4'hf), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
      .dma_req_in(req), .active_in(act), .block_done_in(bd), .chain_on_in(chn),
      .error_in(er), .abort_in(ab), .tc_in(tc), .end_wr_in(ew), .src_end_in(se),
      .dst_end_in(de), .end_ch_in(ec), .channel_on_out(chon), .src_go_out(sgo),
      .dst_go_out(dgo), .busy_out(busy), .irq_abort_out(ia), .irq_error_out(ie),
      .irq_tc_out(it));
   dcc_periph_model i_periph (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .ready_in(rdy), .dma_req_out(req));

   // Clock, 10 ns period
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   // Config word from its fields
   function automatic logic [31:0] cfg(input logic dh, input logic [3:0] ds,
         input logic sh, input logic [3:0] ss, input logic [2:0] m);
      return {18'h0, dh, ds, 1'b0, sh, ss, m};
   endfunction

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask

   // Bus access, held until waitrequest is sampled low
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (wreq !== 1'b0 && n < 40);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 40) begin
         err_total++;
         end_of_test();
      end
   endtask

   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask

   // One-cycle events {tc, abort, error, block}, interrupts caught after
   task automatic pulse(input logic [3:0] k, input logic [7:0] m);
      @(posedge clk_sys_in);
      {tc, ab, er, bd} <= {{8{k[3]}}, {8{k[2]}}, {8{k[1]}}, {8{k[0]}}} & {4{m}};
      @(posedge clk_sys_in);
      {tc, ab, er, bd} <= 32'h0;
      @(posedge clk_sys_in);
      irq_q = {it, ia, ie};
   endtask

   task automatic settle;
      repeat (5) @(posedge clk_sys_in);
   endtask

   // Main sequence
   initial begin
      {rst_n_in, rd, wr, adr, wd, act, chn, tc, ab, er, bd, ew, se, de, ec, rdy} = '0;
      err_total = 0;
      n_tests = 0;
      repeat (12) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      for (int n = 0; n < 8; n++) begin
         b = 12'h100 + 12'(n * 32);
         rdc("cfg_reset", b + 12'h004, cfg(1, 0, 1, 0, 3'h7));
         acc(1'b1, b + 12'h008, 32'h12345600 + 32'(n));
         acc(1'b1, b + 12'h00c, 32'hfedcba00 - 32'(n));
         acc(1'b1, b + 12'h010, 32'h80000000 + 32'(n * 256 + n % 4));
      end
      for (int n = 0; n < 8; n++) begin
         b = 12'h100 + 12'(n * 32);
         rdc("src", b + 12'h008, 32'h12345600 + 32'(n));
         rdc("dst", b + 12'h00c, 32'hfedcba00 - 32'(n));
         rdc("ptr", b + 12'h010, 32'h80000000 + 32'(n * 256 + n % 4));
      end
      acc(1'b1, 12'h114, 32'hffffffff);
      rdc("unmapped", 12'h114, 32'h0);
      rdc("outside", 12'h0fc, 32'h0);
      acc(1'b1, 12'h120, 32'h1);
      chn <= 8'h02;
      pulse(4'b0001, 8'h02);
      pulse(4'b0001, 8'h02);
      pulse(4'b0010, 8'h02);
      chk("irq_err_masked", 32'h0, {8'h0, irq_q});
      pulse(4'b0100, 8'h02);
      chk("irq_abt_masked", 32'h0, {8'h0, irq_q});
      pulse(4'b1000, 8'h02);
      chk("irq_tc_masked", 32'h0, {8'h0, irq_q});
      chk("chan_on", 32'h2, {24'h0, chon});
      rdc("count", 12'h124, cfg(1, 0, 1, 0, 3'h7) | 32'h40000);
      chn <= 8'h00;
      pulse(4'b0001, 8'h02);
      rdc("count_nochain", 12'h124, cfg(1, 0, 1, 0, 3'h7) | 32'h40000);
      acc(1'b1, 12'h120, 32'h0);
      acc(1'b1, 12'h120, 32'h1);
      rdc("count_clear", 12'h124, cfg(1, 0, 1, 0, 3'h7));
      for (int k = 0; k < 8; k++) begin
         acc(1'b1, 12'h124, cfg(1, 0, 1, 0, 3'(k)));
         pulse(4'b1110, 8'h02);
         chk("irq_mask", {8'h0, k[0] ? 8'h0 : 8'h02, k[2] ? 8'h0 : 8'h02,
            k[1] ? 8'h0 : 8'h02}, {8'h0, irq_q});
      end
      act <= 8'h0c;
      settle();
      chk("busy", 32'h4, {24'h0, busy});
      rdc("busy_flag", 12'h144, cfg(1, 0, 1, 0, 3'h7) | 32'h100);
      rdc("busy_other", 12'h164, cfg(1, 0, 1, 0, 3'h7));
      act <= 8'h00;
      ec <= 3'h3;
      se <= 32'h0badf00c;
      de <= 32'h600dcafe;
      ew <= 8'h08;
      @(posedge clk_sys_in);
      ew <= 8'h00;
      settle();
      rdc("src_end", 12'h168, 32'h0badf00c);
      rdc("dst_end", 12'h16c, 32'h600dcafe);
      acc(1'b1, 12'h100, 32'h3);
      acc(1'b1, 12'h104, cfg(1, 4'h9, 1, 4'h5, 3'h7));
      settle();
      chk("go_wait", 32'h0, {30'h0, sgo[0], dgo[0]});
      rdy <= 16'h0200;
      settle();
      chk("go_dst", 32'h1, {30'h0, sgo[0], dgo[0]});
      rdy <= 16'h0220;
      settle();
      chk("go_both", 32'h3, {30'h0, sgo[0], dgo[0]});
      rdy <= 16'h0000;
      acc(1'b1, 12'h104, cfg(0, 4'h9, 0, 4'h5, 3'h7));
      settle();
      chk("go_nohs", 32'h3, {30'h0, sgo[0], dgo[0]});
      acc(1'b1, 12'h104, cfg(1, 4'h9, 1, 4'h5, 3'h7));
      acc(1'b1, 12'h100, 32'h1);
      settle();
      chk("go_swmode", 32'h3, {30'h0, sgo[0], dgo[0]});
      end_of_test();
   end
endmodule // tb_dma_channel_config_regs

bind dcc_regs dcc_regs_sva i_sva (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_waitrequest_out(avs_waitrequest_out), .active_in(active_in),
   .busy_out(busy_out), .abort_in(abort_in), .error_in(error_in), .tc_in(tc_in),
   .irq_abort_out(irq_abort_out), .irq_error_out(irq_error_out), .irq_tc_out(irq_tc_out));
